// ==== rtl/cae_exec.sv ====
/*
 * cae_exec: execution datapath of an 8-bit risc core (arithmetic, logic,
 * multiply, pointer jump/call, compare-and-skip) behind an AXI4-Lite
 * slave. Software loads operands, writes the control word to start one
 * operation and reads back destination, product, pc and flags.
 * Assumes one 200 MHz clock and a synchronous active-high reset.
 */
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
// Function
// - add and add-with-carry write sum, set Z C N V H, one cycle.
// - word add immediate on 16-bit pair, sets Z C N V S, two cycles.
// - register subtract and with-borrow store difference, Z C N V H.
// - immediate subtract and with-borrow store difference, Z C N V H.
// - word subtract immediate on 16-bit pair, sets Z C N V S.
// - AND register or immediate, updates only Z N V S, one cycle.
// - OR register or immediate, updates Z N V, one cycle.
// - XOR stores bitwise difference in destination, Z N V, one cycle.
// - mask set ORs immediate into destination, Z N V, one cycle.
// - mask clear ANDs with 0xFF minus mask, Z N V, one cycle.
// - test ANDs register with itself, sets Z N V, one cycle.
// - zeroing XORs register with itself, sets Z N V, one cycle.
// - integer multiplies place 16-bit product in pair, Z C, two cycles.
// - fractional multiplies place product shifted left one, Z C.
// - pointer jump loads pc from pointer, flags kept, two cycles.
// - pointer call saves return address, loads pc, three cycles.
// - equal skip advances pc 2 or 3 when equal, 1/2/3 cycles.
`timescale 1ns/1ps
`default_nettype none

module cae_exec (
   // clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   // register bus
   input  wire cae_pkg::cae_axi_req_type axi_req,
   output var  cae_pkg::cae_axi_rsp_type axi_rsp,
   // execution state
   output var  logic                     exec_busy
);
   import cae_pkg::*;

   // sets Z N V S from an 8-bit result and its overflow
   function automatic logic [7:0] flags_znv(input logic [7:0] f,
                                            input logic [7:0] r,
                                            input logic       v);
      logic [7:0] o;
      o              = f;
      o[CAE_FLAG_Z]  = (r == CAE_RST_BYTE);
      o[CAE_FLAG_N]  = r[7];
      o[CAE_FLAG_V]  = v;
      o[CAE_FLAG_S]  = r[7] ^ v;
      return o;
   endfunction : flags_znv

   // byte-lane merge of a bus write into an old word
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] neu,
                                              input logic [3:0]  strb);
      logic [31:0] o;
      o = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            o[i*8 +: 8] = neu[i*8 +: 8];
         end
      end
      return o;
   endfunction : lane_merge

   // architectural state
   cae_state_type state_reg, state_next;
   logic [1:0]    cnt_reg, cnt_next;
   cae_op_type    op_reg, op_next;
   logic          long_reg, long_next;
   logic [7:0]    dest_reg, dest_next;
   logic [7:0]    source_reg, source_next;
   logic [15:0]   word_reg, word_next;
   logic [15:0]   pointer_reg, pointer_next;
   logic [15:0]   pc_reg, pc_next;
   logic [7:0]    flags_reg, flags_next;
   logic [15:0]   product_reg, product_next;
   logic [15:0]   return_reg, return_next;
   logic          done_reg, done_next;
   logic          illegal_reg, illegal_next;
   logic [1:0]    last_cyc_reg, last_cyc_next;
   logic          busy_reg, busy_next;

   // bus state
   logic            aw_hold_reg, aw_hold_next;
   logic [7:0]      aw_addr_reg, aw_addr_next;
   logic            w_hold_reg, w_hold_next;
   logic [31:0]     w_data_reg, w_data_next;
   logic [3:0]      w_strb_reg, w_strb_next;
   cae_axi_rsp_type rsp_reg, rsp_next;

   // datapath results
   logic [7:0]  ex_dest;
   logic [15:0] ex_word;
   logic [15:0] ex_product;
   logic [15:0] ex_pc;
   logic [15:0] ex_return;
   logic [7:0]  ex_flags;
   logic [1:0]  ex_cycles;
   logic        ex_illegal;

   // arithmetic intermediates
   logic        add_cin, sub_cin, sgn_a, sgn_b;
   logic [8:0]  add9, sub9;
   logic [4:0]  add5, sub5;
   logic [16:0] wadd17, wsub17;
   logic [8:0]  mul_a, mul_b;
   logic [17:0] mul_raw;
   logic [15:0] mul_prod;
   logic [31:0] wr_merged;
   logic        do_write, commit;

   // shared adders; carry only enters for the with-carry variants
   always_comb begin
      add_cin = (op_reg == CAE_OP_ADD_CARRY) & flags_reg[CAE_FLAG_C];
      sub_cin = ((op_reg == CAE_OP_SUB_BORROW) |
                 (op_reg == CAE_OP_SUB_IMM_BORROW)) & flags_reg[CAE_FLAG_C];
      add9 = {1'b0, dest_reg} + {1'b0, source_reg} + {8'h00, add_cin};
      add5 = {1'b0, dest_reg[3:0]} + {1'b0, source_reg[3:0]}
             + {4'h0, add_cin};
      sub9 = {1'b0, dest_reg} - {1'b0, source_reg} - {8'h00, sub_cin};
      sub5 = {1'b0, dest_reg[3:0]} - {1'b0, source_reg[3:0]}
             - {4'h0, sub_cin};
      wadd17 = {1'b0, word_reg} + {9'h000, source_reg};
      wsub17 = {1'b0, word_reg} - {9'h000, source_reg};
   end

   // one 9x9 signed multiplier serves all six products
   always_comb begin
      sgn_a = (op_reg == CAE_OP_SIGNED_PROD) | (op_reg == CAE_OP_MIXED_PROD)
            | (op_reg == CAE_OP_SIGNED_FRAC) | (op_reg == CAE_OP_MIXED_FRAC);
      sgn_b = (op_reg == CAE_OP_SIGNED_PROD) | (op_reg == CAE_OP_SIGNED_FRAC);
      mul_a    = {sgn_a & dest_reg[7], dest_reg};
      mul_b    = {sgn_b & source_reg[7], source_reg};
      mul_raw  = 18'($signed(mul_a) * $signed(mul_b));
      mul_prod = mul_raw[15:0];
   end

   // operation decode; results are committed only at the last cycle
   always_comb begin
      ex_dest    = dest_reg;
      ex_word    = word_reg;
      ex_product = product_reg;
      ex_pc      = pc_reg + CAE_PC_STEP;
      ex_return  = return_reg;
      ex_flags   = flags_reg;
      ex_cycles  = CAE_CYC_ONE;
      ex_illegal = 1'b0;
      unique case (op_reg)
         CAE_OP_ADD, CAE_OP_ADD_CARRY: begin
            ex_dest  = add9[7:0];
            ex_flags = flags_znv(flags_reg, add9[7:0],
                          (dest_reg[7] ~^ source_reg[7])
                          & (add9[7] ^ dest_reg[7]));
            ex_flags[CAE_FLAG_C] = add9[8];
            ex_flags[CAE_FLAG_H] = add5[4];
         end
         CAE_OP_SUB, CAE_OP_SUB_BORROW,
         CAE_OP_SUB_IMM, CAE_OP_SUB_IMM_BORROW: begin
            ex_dest  = sub9[7:0];
            ex_flags = flags_znv(flags_reg, sub9[7:0],
                          (dest_reg[7] ^ source_reg[7])
                          & (sub9[7] ^ dest_reg[7]));
            ex_flags[CAE_FLAG_C] = sub9[8];
            ex_flags[CAE_FLAG_H] = sub5[4];
         end
         CAE_OP_WORD_ADD_IMM: begin
            ex_word   = wadd17[15:0];
            ex_cycles = CAE_CYC_TWO;
            ex_flags[CAE_FLAG_Z] = (wadd17[15:0] == CAE_RST_WORD);
            ex_flags[CAE_FLAG_N] = wadd17[15];
            ex_flags[CAE_FLAG_V] = ~word_reg[15] & wadd17[15];
            ex_flags[CAE_FLAG_C] = word_reg[15] & ~wadd17[15];
            ex_flags[CAE_FLAG_S] = wadd17[15] ^ (~word_reg[15] & wadd17[15]);
         end
         CAE_OP_WORD_SUB_IMM: begin
            ex_word   = wsub17[15:0];
            ex_cycles = CAE_CYC_TWO;
            ex_flags[CAE_FLAG_Z] = (wsub17[15:0] == CAE_RST_WORD);
            ex_flags[CAE_FLAG_N] = wsub17[15];
            ex_flags[CAE_FLAG_V] = word_reg[15] & ~wsub17[15];
            ex_flags[CAE_FLAG_C] = wsub17[15] & ~word_reg[15];
            ex_flags[CAE_FLAG_S] = wsub17[15] ^ (word_reg[15] & ~wsub17[15]);
         end
         CAE_OP_AND, CAE_OP_AND_IMM: begin
            ex_dest  = dest_reg & source_reg;
            ex_flags = flags_znv(flags_reg, ex_dest, 1'b0);
         end
         CAE_OP_OR, CAE_OP_OR_IMM: begin
            ex_dest  = dest_reg | source_reg;
            ex_flags = flags_znv(flags_reg, ex_dest, 1'b0);
         end
         CAE_OP_XOR: begin
            ex_dest  = dest_reg ^ source_reg;
            ex_flags = flags_znv(flags_reg, ex_dest, 1'b0);
         end
         CAE_OP_MASK_SET: begin
            ex_dest  = dest_reg | source_reg;
            ex_flags = flags_znv(flags_reg, ex_dest, 1'b0);
         end
         CAE_OP_MASK_CLEAR: begin
            ex_dest  = dest_reg & (CAE_ALL_ONES - source_reg);
            ex_flags = flags_znv(flags_reg, ex_dest, 1'b0);
         end
         CAE_OP_ZERO_MINUS: begin
            ex_dest  = dest_reg & dest_reg;
            ex_flags = flags_znv(flags_reg, ex_dest, 1'b0);
         end
         CAE_OP_REG_ZEROING: begin
            ex_dest  = dest_reg ^ dest_reg;
            ex_flags = flags_znv(flags_reg, ex_dest, 1'b0);
         end
         CAE_OP_UNSIGNED_PROD, CAE_OP_SIGNED_PROD, CAE_OP_MIXED_PROD: begin
            ex_product = mul_prod;
            ex_cycles  = CAE_CYC_TWO;
            ex_flags[CAE_FLAG_Z] = (mul_prod == CAE_RST_WORD);
            ex_flags[CAE_FLAG_C] = mul_prod[15];
         end
         CAE_OP_FRACTION_PROD, CAE_OP_SIGNED_FRAC, CAE_OP_MIXED_FRAC: begin
            ex_product = {mul_prod[14:0], 1'b0};
            ex_cycles  = CAE_CYC_TWO;
            // carry is the bit shifted out, zero tests the shifted word
            ex_flags[CAE_FLAG_Z] = ({mul_prod[14:0], 1'b0} == CAE_RST_WORD);
            ex_flags[CAE_FLAG_C] = mul_prod[15];
         end
         CAE_OP_POINTER_JUMP: begin
            ex_pc     = pointer_reg;
            ex_cycles = CAE_CYC_TWO;
         end
         CAE_OP_POINTER_CALL: begin
            ex_return = pc_reg + CAE_PC_STEP;
            ex_pc     = pointer_reg;
            ex_cycles = CAE_CYC_THREE;
         end
         CAE_OP_EQUAL_SKIP: begin
            // skipped word count depends on the length of the next opcode
            if (dest_reg == source_reg) begin
               ex_pc     = pc_reg + (long_reg ? CAE_PC_SKIP_LONG
                                              : CAE_PC_SKIP);
               ex_cycles = long_reg ? CAE_CYC_THREE : CAE_CYC_TWO;
            end
         end
         default: begin
            ex_illegal = 1'b1;
         end
      endcase
   end

   // write accepted once both halves are held and the response is free
   always_comb begin
      do_write  = aw_hold_reg & w_hold_reg & ~rsp_reg.bvalid;
      wr_merged = lane_merge(CAE_RST_DATA, w_data_reg, w_strb_reg);
      commit    = (state_reg == CAE_ST_EXEC) & (cnt_reg == ex_cycles - 2'd1);
   end

   // execution control and register file next values
   always_comb begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      op_next       = op_reg;
      long_next     = long_reg;
      dest_next     = dest_reg;
      source_next   = source_reg;
      word_next     = word_reg;
      pointer_next  = pointer_reg;
      pc_next       = pc_reg;
      flags_next    = flags_reg;
      product_next  = product_reg;
      return_next   = return_reg;
      done_next     = done_reg;
      illegal_next  = illegal_reg;
      last_cyc_next = last_cyc_reg;
      // operands are frozen while busy so the datapath stays stable
      if (do_write && (state_reg == CAE_ST_IDLE)) begin
         unique case (aw_addr_reg)
            CAE_OFS_CTRL: begin
               op_next   = cae_op_type'(
                              w_data_reg[CAE_CTRL_OP_MSB:CAE_CTRL_OP_LSB]);
               long_next = w_data_reg[CAE_CTRL_LONG_BIT];
               state_next = CAE_ST_EXEC;
               cnt_next   = 2'd0;
               done_next  = 1'b0;
            end
            CAE_OFS_DEST:    dest_next    = wr_merged[7:0];
            CAE_OFS_SOURCE:  source_next  = wr_merged[7:0];
            CAE_OFS_WORD:    word_next    = wr_merged[15:0];
            CAE_OFS_POINTER: pointer_next = wr_merged[15:0];
            CAE_OFS_PC:      pc_next      = wr_merged[15:0];
            CAE_OFS_FLAGS:   flags_next   = wr_merged[7:0];
            default: begin
            end
         endcase
      end
      if (state_reg == CAE_ST_EXEC) begin
         cnt_next = cnt_reg + 2'd1;
      end
      if (commit) begin
         dest_next     = ex_dest;
         word_next     = ex_word;
         product_next  = ex_product;
         pc_next       = ex_pc;
         return_next   = ex_return;
         flags_next    = ex_flags;
         illegal_next  = ex_illegal;
         last_cyc_next = ex_cycles;
         done_next     = 1'b1;
         state_next    = CAE_ST_IDLE;
      end
      busy_next = (state_next == CAE_ST_EXEC);
   end

   // AXI4-Lite channel handling and read mux
   always_comb begin
      aw_hold_next = aw_hold_reg;
      aw_addr_next = aw_addr_reg;
      w_hold_next  = w_hold_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      rsp_next     = rsp_reg;
      if (axi_req.awvalid && rsp_reg.awready) begin
         aw_hold_next = 1'b1;
         aw_addr_next = axi_req.awaddr;
      end
      if (axi_req.wvalid && rsp_reg.wready) begin
         w_hold_next = 1'b1;
         w_data_next = axi_req.wdata;
         w_strb_next = axi_req.wstrb;
      end
      if (rsp_reg.bvalid && axi_req.bready) begin
         rsp_next.bvalid = 1'b0;
      end
      if (do_write) begin
         aw_hold_next    = 1'b0;
         w_hold_next     = 1'b0;
         rsp_next.bvalid = 1'b1;
         rsp_next.bresp  = (aw_addr_reg > CAE_OFS_FLAGS)
                           ? CAE_RESP_SLVERR : CAE_RESP_OKAY;
      end
      rsp_next.awready = ~aw_hold_next;
      rsp_next.wready  = ~w_hold_next;
      if (rsp_reg.rvalid && axi_req.rready) begin
         rsp_next.rvalid = 1'b0;
      end
      if (axi_req.arvalid && rsp_reg.arready) begin
         rsp_next.rvalid = 1'b1;
         rsp_next.rresp  = CAE_RESP_OKAY;
         rsp_next.rdata  = CAE_RST_DATA;
         unique case (axi_req.araddr)
            CAE_OFS_CTRL: begin
               rsp_next.rdata[CAE_CTRL_OP_MSB:CAE_CTRL_OP_LSB] = op_reg;
               rsp_next.rdata[CAE_CTRL_LONG_BIT] = long_reg;
            end
            CAE_OFS_DEST:    rsp_next.rdata[7:0]  = dest_reg;
            CAE_OFS_SOURCE:  rsp_next.rdata[7:0]  = source_reg;
            CAE_OFS_WORD:    rsp_next.rdata[15:0] = word_reg;
            CAE_OFS_POINTER: rsp_next.rdata[15:0] = pointer_reg;
            CAE_OFS_PC:      rsp_next.rdata[15:0] = pc_reg;
            CAE_OFS_FLAGS:   rsp_next.rdata[7:0]  = flags_reg;
            CAE_OFS_PRODUCT: rsp_next.rdata[15:0] = product_reg;
            CAE_OFS_RETURN:  rsp_next.rdata[15:0] = return_reg;
            CAE_OFS_STATUS: begin
               rsp_next.rdata[CAE_STAT_BUSY]    = busy_reg;
               rsp_next.rdata[CAE_STAT_DONE]    = done_reg;
               rsp_next.rdata[CAE_STAT_ILLEGAL] = illegal_reg;
               rsp_next.rdata[CAE_STAT_CYC_LSB +: 2] = last_cyc_reg;
            end
            default: rsp_next.rresp = CAE_RESP_SLVERR;
         endcase
      end
      rsp_next.arready = ~rsp_next.rvalid;
   end

   // state registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg    <= CAE_ST_IDLE;
         cnt_reg      <= 2'd0;
         op_reg       <= CAE_OP_ADD;
         long_reg     <= 1'b0;
         dest_reg     <= CAE_RST_BYTE;
         source_reg   <= CAE_RST_BYTE;
         word_reg     <= CAE_RST_WORD;
         pointer_reg  <= CAE_RST_WORD;
         pc_reg       <= CAE_RST_WORD;
         flags_reg    <= CAE_RST_BYTE;
         product_reg  <= CAE_RST_WORD;
         return_reg   <= CAE_RST_WORD;
         done_reg     <= 1'b0;
         illegal_reg  <= 1'b0;
         last_cyc_reg <= 2'd0;
         busy_reg     <= 1'b0;
         aw_hold_reg  <= 1'b0;
         aw_addr_reg  <= CAE_RST_BYTE;
         w_hold_reg   <= 1'b0;
         w_data_reg   <= CAE_RST_DATA;
         w_strb_reg   <= 4'h0;
         rsp_reg      <= '0;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         op_reg       <= op_next;
         long_reg     <= long_next;
         dest_reg     <= dest_next;
         source_reg   <= source_next;
         word_reg     <= word_next;
         pointer_reg  <= pointer_next;
         pc_reg       <= pc_next;
         flags_reg    <= flags_next;
         product_reg  <= product_next;
         return_reg   <= return_next;
         done_reg     <= done_next;
         illegal_reg  <= illegal_next;
         last_cyc_reg <= last_cyc_next;
         busy_reg     <= busy_next;
         aw_hold_reg  <= aw_hold_next;
         aw_addr_reg  <= aw_addr_next;
         w_hold_reg   <= w_hold_next;
         w_data_reg   <= w_data_next;
         w_strb_reg   <= w_strb_next;
         rsp_reg      <= rsp_next;
      end
   end

   // outputs straight from flops
   always_comb begin
      axi_rsp   = rsp_reg;
      exec_busy = busy_reg;
   end

endmodule : cae_exec

`default_nettype wire

// ==== inc/cae_pkg.sv ====
/*
 * cae_pkg: constants, opcode and state encodings and bus carriers for
 * the cpu arithmetic/branch execution block (cae_exec).
 * Assumes a 32-bit AXI4-Lite master with 8-bit byte addresses.
 */
package cae_pkg;

   // register byte offsets, one aligned word each
   localparam logic [7:0] CAE_OFS_CTRL    = 8'h00;
   localparam logic [7:0] CAE_OFS_DEST    = 8'h04;
   localparam logic [7:0] CAE_OFS_SOURCE  = 8'h08;
   localparam logic [7:0] CAE_OFS_WORD    = 8'h0C;
   localparam logic [7:0] CAE_OFS_POINTER = 8'h10;
   localparam logic [7:0] CAE_OFS_PC      = 8'h14;
   localparam logic [7:0] CAE_OFS_FLAGS   = 8'h18;
   localparam logic [7:0] CAE_OFS_PRODUCT = 8'h1C;
   localparam logic [7:0] CAE_OFS_RETURN  = 8'h20;
   localparam logic [7:0] CAE_OFS_STATUS  = 8'h24;

   // control word fields
   localparam int CAE_CTRL_OP_LSB   = 0;
   localparam int CAE_CTRL_OP_MSB   = 4;
   localparam int CAE_CTRL_LONG_BIT = 8;

   // flag bit positions
   localparam int CAE_FLAG_C = 0;
   localparam int CAE_FLAG_Z = 1;
   localparam int CAE_FLAG_N = 2;
   localparam int CAE_FLAG_V = 3;
   localparam int CAE_FLAG_S = 4;
   localparam int CAE_FLAG_H = 5;

   // status word fields
   localparam int CAE_STAT_BUSY    = 0;
   localparam int CAE_STAT_DONE    = 1;
   localparam int CAE_STAT_ILLEGAL = 2;
   localparam int CAE_STAT_CYC_LSB = 8;

   // reset values and the all-ones byte
   localparam logic [7:0]  CAE_RST_BYTE  = 8'h00;
   localparam logic [15:0] CAE_RST_WORD  = 16'h0000;
   localparam logic [31:0] CAE_RST_DATA  = 32'h0000_0000;
   localparam logic [7:0]  CAE_ALL_ONES  = 8'hFF;

   // execution lengths in clock cycles
   localparam logic [1:0] CAE_CYC_ONE   = 2'h1;
   localparam logic [1:0] CAE_CYC_TWO   = 2'h2;
   localparam logic [1:0] CAE_CYC_THREE = 2'h3;

   // program counter steps in words
   localparam logic [15:0] CAE_PC_STEP      = 16'h0001;
   localparam logic [15:0] CAE_PC_SKIP      = 16'h0002;
   localparam logic [15:0] CAE_PC_SKIP_LONG = 16'h0003;

   // bus responses
   localparam logic [1:0] CAE_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CAE_RESP_SLVERR = 2'h2;

   typedef enum logic [4:0] {
      CAE_OP_ADD            = 5'b00000,
      CAE_OP_ADD_CARRY      = 5'b00001,
      CAE_OP_WORD_ADD_IMM   = 5'b00010,
      CAE_OP_SUB            = 5'b00011,
      CAE_OP_SUB_IMM        = 5'b00100,
      CAE_OP_SUB_BORROW     = 5'b00101,
      CAE_OP_SUB_IMM_BORROW = 5'b00110,
      CAE_OP_WORD_SUB_IMM   = 5'b00111,
      CAE_OP_AND            = 5'b01000,
      CAE_OP_AND_IMM        = 5'b01001,
      CAE_OP_OR             = 5'b01010,
      CAE_OP_OR_IMM         = 5'b01011,
      CAE_OP_XOR            = 5'b01100,
      CAE_OP_MASK_SET       = 5'b01101,
      CAE_OP_MASK_CLEAR     = 5'b01110,
      CAE_OP_ZERO_MINUS     = 5'b01111,
      CAE_OP_REG_ZEROING    = 5'b10000,
      CAE_OP_UNSIGNED_PROD  = 5'b10001,
      CAE_OP_SIGNED_PROD    = 5'b10010,
      CAE_OP_MIXED_PROD     = 5'b10011,
      CAE_OP_FRACTION_PROD  = 5'b10100,
      CAE_OP_SIGNED_FRAC    = 5'b10101,
      CAE_OP_MIXED_FRAC     = 5'b10110,
      CAE_OP_POINTER_JUMP   = 5'b10111,
      CAE_OP_POINTER_CALL   = 5'b11000,
      CAE_OP_EQUAL_SKIP     = 5'b11001
   } cae_op_type;

   typedef enum logic [0:0] {
      CAE_ST_IDLE = 1'b0,
      CAE_ST_EXEC = 1'b1
   } cae_state_type;

   typedef struct packed {
      logic [7:0]  awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [7:0]  araddr;
      logic        arvalid;
      logic        rready;
   } cae_axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } cae_axi_rsp_type;

endpackage : cae_pkg

// ==== sim/cae_exec_sva.sv ====
/* cae_exec_sva: bus and execution-length checks on the cae_exec ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module cae_exec_sva (
   // clock and reset
   input wire logic                     clk_sys,
   input wire logic                     reset,
   // bus and state
   input wire cae_pkg::cae_axi_req_type axi_req,
   input wire cae_pkg::cae_axi_rsp_type axi_rsp,
   input wire logic                     exec_busy
);
   import cae_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // one write accepted, then answered within a few cycles
   sequence s_wr_taken;
      axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
   endsequence
   AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:4] axi_rsp.bvalid) else $error("write unanswered");
   AST_AW_BLOCK: assert property (s_wr_taken |=> !axi_rsp.awready) else $error("aw not held off");
   AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("bresp dropped");
   AST_R_ANSWER: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("read late");
   AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("rdata moved");
   AST_R_DONE: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid) else $error("rvalid stuck");
   AST_AR_LOW: assert property (axi_rsp.rvalid |-> !axi_rsp.arready) else $error("ar open");
   // no operation runs past the three-cycle call
   AST_BUSY_MAX: assert property ($rose(exec_busy) |-> ##[1:3] !exec_busy) else $error("busy too long");
   AST_BUSY_CAP: assert property (exec_busy [*3] |=> !exec_busy) else $error("busy over 3");
endmodule : cae_exec_sva
bind cae_exec cae_exec_sva u_sva (.clk_sys(clk_sys), .reset(reset),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .exec_busy(exec_busy));
`default_nettype wire

// ==== sim/test_cae_exec.sv ====
/* test_cae_exec: directed bench for cae_exec over its AXI4-Lite port.
   Assumes the package offsets, opcodes and flag positions. */
`timescale 1ns/1ps
`default_nettype none
module test_cae_exec;
   import cae_pkg::*;
   logic clk_sys, reset, exec_busy;
   cae_axi_req_type req;
   cae_axi_rsp_type rsp;
   logic [31:0] rdat;
   logic [1:0] resp;
   int failures = 0, comparisons = 0, cyc = 0, busy_cnt = 0;
   cae_exec u_dut (.clk_sys(clk_sys), .reset(reset), .axi_req(req),
      .axi_rsp(rsp), .exec_busy(exec_busy));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // busy length and hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (exec_busy === 1'b1) busy_cnt++;
      if (cyc == 5000) begin
         failures++;
         end_sim();
      end
   end
   task end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask : chk
   // write both channels together, release each as it is taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {req.awaddr, req.wdata, req.wstrb} <= {a, d, 4'hF};
      {req.awvalid, req.wvalid, req.bready} <= 3'b111;
      do begin
         @(posedge clk_sys);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      req.bready <= 1'b0;
      resp = rsp.bresp;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      {req.araddr, req.arvalid, req.rready} <= {a, 2'b11};
      do begin
         @(posedge clk_sys);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      req.rready <= 1'b0;
      {rdat, resp} = {rsp.rdata, rsp.rresp};
   endtask : rd
   // load operands, start, wait out busy, check result, flags, length
   task t_op(input logic [4:0] op, input logic [7:0] d, s, input logic l,
      input logic [7:0] ra, input logic [31:0] ev, input logic [7:0] ef,
      input int ec);
      wr(CAE_OFS_DEST, {24'h0, d});
      wr(CAE_OFS_SOURCE, {24'h0, s});
      wr(CAE_OFS_FLAGS, 32'h0);
      wr(CAE_OFS_PC, 32'h0);
      busy_cnt = 0;
      wr(CAE_OFS_CTRL, {23'h0, l, 3'h0, op});
      while (exec_busy !== 1'b0) @(posedge clk_sys);
      rd(ra);
      chk(rdat, ev);
      rd(CAE_OFS_FLAGS);
      chk(rdat, {24'h0, ef});
      chk(32'(busy_cnt), 32'(ec));
   endtask : t_op
   task t_arith;
      t_op(CAE_OP_ADD, 8'h0F, 8'h01, 0, CAE_OFS_DEST, 32'h10, 8'h20, 1);
      t_op(CAE_OP_SUB, 8'h00, 8'h01, 0, CAE_OFS_DEST, 32'hFF, 8'h35, 1);
      t_op(CAE_OP_MASK_CLEAR, 8'hFF, 8'h0F, 0, CAE_OFS_DEST, 32'hF0, 8'h14, 1);
      t_op(CAE_OP_UNSIGNED_PROD, 8'hFF, 8'hFF, 0, CAE_OFS_PRODUCT, 32'hFE01, 8'h01, 2);
      t_op(CAE_OP_SUB_IMM, 8'h80, 8'h01, 0, CAE_OFS_DEST, 32'h7F, 8'h38, 1);
      t_op(CAE_OP_AND, 8'hF0, 8'h0F, 0, CAE_OFS_DEST, 32'h0, 8'h02, 1);
      t_op(CAE_OP_OR_IMM, 8'h80, 8'h01, 0, CAE_OFS_DEST, 32'h81, 8'h14, 1);
      t_op(CAE_OP_XOR, 8'h55, 8'hFF, 0, CAE_OFS_DEST, 32'hAA, 8'h14, 1);
      t_op(CAE_OP_MASK_SET, 8'h01, 8'h80, 0, CAE_OFS_DEST, 32'h81, 8'h14, 1);
      t_op(CAE_OP_ZERO_MINUS, 8'h80, 8'h00, 0, CAE_OFS_DEST, 32'h80, 8'h14, 1);
      t_op(CAE_OP_REG_ZEROING, 8'h5A, 8'h00, 0, CAE_OFS_DEST, 32'h0, 8'h02, 1);
      t_op(CAE_OP_SIGNED_PROD, 8'hFF, 8'h02, 0, CAE_OFS_PRODUCT, 32'hFFFE, 8'h01, 2);
      t_op(CAE_OP_FRACTION_PROD, 8'hFF, 8'hFF, 0, CAE_OFS_PRODUCT, 32'hFC02, 8'h01, 2);
      wr(CAE_OFS_WORD, 32'h0000_FFFF);
      t_op(CAE_OP_WORD_ADD_IMM, 8'h00, 8'h01, 0, CAE_OFS_WORD, 32'h0, 8'h03, 2);
      t_op(CAE_OP_WORD_SUB_IMM, 8'h00, 8'h01, 0, CAE_OFS_WORD, 32'hFFFF, 8'h15, 2);
      $display("arith test done");
   endtask : t_arith
   task t_flow;
      wr(CAE_OFS_POINTER, 32'h0000_1234);
      t_op(CAE_OP_POINTER_CALL, 8'h00, 8'h00, 0, CAE_OFS_PC, 32'h1234, 8'h00, 3);
      rd(CAE_OFS_RETURN);
      chk(rdat, 32'h1);
      t_op(CAE_OP_EQUAL_SKIP, 8'h5A, 8'h5A, 0, CAE_OFS_PC, 32'h2, 8'h00, 2);
      t_op(CAE_OP_POINTER_JUMP, 8'h00, 8'h00, 0, CAE_OFS_PC, 32'h1234, 8'h00, 2);
      t_op(CAE_OP_EQUAL_SKIP, 8'h5A, 8'hA5, 0, CAE_OFS_PC, 32'h1, 8'h00, 1);
      t_op(CAE_OP_EQUAL_SKIP, 8'h5A, 8'h5A, 1, CAE_OFS_PC, 32'h3, 8'h00, 3);
      rd(CAE_OFS_STATUS);
      chk(rdat, 32'h0000_0302);
      rd(8'h28);
      chk({30'h0, resp}, {30'h0, CAE_RESP_SLVERR});
      $display("flow test done");
   endtask : t_flow
   initial begin
      req = '0;
      reset = 1'b1;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      t_arith();
      t_flow();
      end_sim();
   end
endmodule : test_cae_exec
`default_nettype wire
